//--- core/gptc_pkg.sv
// Shared constants and types of the GPIO, pace threshold and test tone register slice
package gptc_pkg;
  // Bus widths
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 24;
  // Register indexes, used directly as addresses on the plain port
  localparam logic [7:0] GPIO_IDX = 8'h06;
  localparam logic [7:0] PACE_IDX = 8'h07;
  localparam logic [7:0] TONE_IDX = 8'h08;
  // Reset values
  localparam logic [23:0] GPIO_RST = 24'h000000;
  localparam logic [23:0] PACE_RST = 24'h242424;
  localparam logic [23:0] TONE_RST = 24'h000000;
  // Writable bits; all others store zero
  localparam logic [23:0] GPIO_WMASK = 24'h010eee;
  localparam logic [23:0] PACE_WMASK = 24'hffffff;
  localparam logic [23:0] TONE_WMASK = 24'hf8001f;
  // Answer to an unmapped or idle read
  localparam logic [23:0] RD_ZERO = 24'h000000;
  // Pin count and per-pin field layout in the GPIO register
  localparam int NPIN = 3;
  localparam int PIN_STRIDE = 4;
  localparam int MODE_OFS = 2;
  localparam int VAL_OFS = 1;
  localparam int IN_OFS = 0;
  localparam int SEC_EN_BIT = 16;
  // Pace threshold fields
  localparam int PACE_W = 8;
  localparam int LEAD1_LSB = 0;
  localparam int LEAD2_LSB = 8;
  localparam int LEAD3_LSB = 16;
  // Test tone fields
  localparam int NELEC = 5;
  localparam int SEL_LSB = 19;
  localparam int WAVE_LSB = 3;
  localparam int INT_BIT = 2;
  localparam int PINOUT_BIT = 1;
  localparam int EN_BIT = 0;
  // Pin mode codes
  typedef enum logic [1:0] {
    PM_HIZ = 2'h0,
    PM_IN = 2'h1,
    PM_PP = 2'h2,
    PM_OD = 2'h3
  } gptc_pin_mode_t;
endpackage

//--- core/gptc_pin_if.sv
// Signals between the register slice and one general-purpose pin driver
`timescale 1ns/1ns
interface gptc_pin_if;
  logic [1:0] mode; // Pin mode field
  logic out_value; // Pin output value bit
  logic sec_en; // Secondary port owns the pin
  logic sec_out; // Secondary port output level
  logic sec_oe_n; // Secondary port enable, low drives
  logic pin_out; // Level to the pad
  logic pin_oe_n; // Pad enable, low drives
  modport ctrl (output mode, out_value, sec_en, sec_out, sec_oe_n, input pin_out, pin_oe_n);
  modport pin (input mode, out_value, sec_en, sec_out, sec_oe_n, output pin_out, pin_oe_n);
endinterface

//--- core/gptc_pin_ctrl.sv
// Output driver of one general-purpose pin
`timescale 1ns/1ns
module gptc_pin_ctrl (
  input wire logic clk_i,
  input wire logic arst_n_i,
  gptc_pin_if.pin pin
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // Mode decode
  wire is_pp = (pin.mode == gptc_pkg::PM_PP);
  wire is_od = (pin.mode == gptc_pkg::PM_OD);
  // Open drain only ever drives low; a one releases the pad
  wire out_next = pin.sec_en ? pin.sec_out : (is_pp & pin.out_value);
  wire oe_n_next = pin.sec_en ? pin.sec_oe_n :
                   is_pp ? 1'b0 :
                   is_od ? pin.out_value : 1'b1;

  // Registered pad controls
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pin.pin_out <= 1'b0;
      pin.pin_oe_n <= 1'b1;
    end
    else
    begin
      pin.pin_out <= out_next;
      pin.pin_oe_n <= oe_n_next;
    end
  end

  chk_pp_drive: assert property (!pin.sec_en && is_pp |=> !pin.pin_oe_n && pin.pin_out == $past(pin.out_value)) else $error("push-pull pin not driven");
  chk_od_pull: assert property (!pin.sec_en && is_od |=> pin.pin_oe_n == $past(pin.out_value) && !pin.pin_out) else $error("open-drain level wrong");
  chk_hiz_release: assert property (!pin.sec_en && !pin.mode[1] |=> pin.pin_oe_n) else $error("pin driven in hi-z or input mode");
  chk_sec_owns: assert property (pin.sec_en |=> pin.pin_oe_n == $past(pin.sec_oe_n) && pin.pin_out == $past(pin.sec_out)) else $error("secondary port not on pin");
endmodule

//--- core/gptc_tone_route.sv
// Test tone routing and waveform decode
`timescale 1ns/1ns
module gptc_tone_route (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [4:0] tone_sel_i,
  input wire logic [1:0] tone_waveform_i,
  input wire logic tone_internal_route_i,
  input wire logic tone_pin_out_i,
  input wire logic tone_enable_i,
  input wire logic cal_mode_i,
  input wire logic gang_mode_i,
  input wire logic slave_mode_i,
  output logic [4:0] electrode_to_cm_o,
  output logic [4:0] electrode_to_tone_o,
  output logic ext_switch_open_o,
  output logic cal_pin_tone_o,
  output logic cal_dac_off_o,
  output logic tone_to_chain_o,
  output logic ac_leadoff_off_o,
  output logic [2:0] wave_sel_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // One-hot waveform: bit0 10 Hz sine, bit1 150 Hz sine, bit2 1 Hz square
  function automatic logic [2:0] wave_decode(input logic [1:0] w);
    wave_decode = w[1] ? 3'h4 : (w[0] ? 3'h2 : 3'h1);
  endfunction

  // Calibration mode wins over the tone
  wire tone_live = tone_enable_i & ~cal_mode_i;
  wire [4:0] to_tone = tone_sel_i & {5{tone_internal_route_i}};
  // External route sends tone out; internal route only with pin-out or in gang
  wire pin_tone = tone_live & (~tone_internal_route_i | tone_pin_out_i | gang_mode_i);
  wire dac_off = gang_mode_i & slave_mode_i & tone_internal_route_i & tone_enable_i;

  // Registered switch controls
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      electrode_to_cm_o <= 5'h1f;
      electrode_to_tone_o <= 5'h00;
      ext_switch_open_o <= 1'b0;
      cal_pin_tone_o <= 1'b0;
      cal_dac_off_o <= 1'b0;
      tone_to_chain_o <= 1'b0;
      ac_leadoff_off_o <= 1'b0;
      wave_sel_o <= 3'h1;
    end
    else
    begin
      electrode_to_cm_o <= ~tone_sel_i;
      electrode_to_tone_o <= to_tone;
      ext_switch_open_o <= tone_internal_route_i;
      cal_pin_tone_o <= pin_tone;
      cal_dac_off_o <= dac_off;
      tone_to_chain_o <= tone_live;
      ac_leadoff_off_o <= tone_enable_i;
      wave_sel_o <= wave_decode(tone_waveform_i);
    end
  end

  chk_cal_priority: assert property (cal_mode_i |=> !tone_to_chain_o) else $error("tone beat calibration");
  chk_leadoff_off: assert property (tone_enable_i |=> ac_leadoff_off_o && (tone_to_chain_o == !$past(cal_mode_i))) else $error("ac lead-off not forced off");
  chk_route_ext: assert property (!tone_internal_route_i && tone_live |=> cal_pin_tone_o && !ext_switch_open_o && electrode_to_tone_o == 5'h00) else $error("external route wrong");
  chk_pin_gate: assert property (tone_internal_route_i && !gang_mode_i && !tone_pin_out_i |=> !cal_pin_tone_o && ext_switch_open_o) else $error("pin tone leaked");
  chk_slave_dac: assert property (gang_mode_i && slave_mode_i && tone_internal_route_i && tone_enable_i |=> cal_dac_off_o) else $error("slave DAC still on");
  chk_wave_square: assert property (tone_waveform_i[1] |=> wave_sel_o == 3'h4) else $error("square not chosen");
endmodule

//--- core/gptc_regs.sv
// GPIO, pace threshold and test tone register slice with pin and tone control
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Two-bit pin mode: hi-z, input, push-pull, open-drain
// - Output value drives pin only in output modes
// - Input bits read sampled level in input mode while the secondary port is off
// - GPIO register resets to zero
// - Three 8-bit pace thresholds, reset 0x24 each
// - Electrode select: common mode, tone, or open
// - Tone type: 10 Hz, 150 Hz sine, 1 Hz square
// - Route bit: external via pin or internal
// - Gang internal: pin connected, slave DAC off
// - Tone-out bit gates pin during internal route
// - Tone enable feeds chain, forces lead-off off
// - Calibration mode beats test tone
// - Test tone register resets to zero
// - Secondary port enable overrides pins 0-2
// - Pin 2 mode bits 11:10, value bit 9
module gptc_regs (
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [23:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [23:0] rdata_o,
  // General-purpose pins
  input wire logic [2:0] pin_in_i,
  output logic [2:0] pin_out_o,
  output logic [2:0] pin_oe_n_o,
  // Secondary port sharing pins 0 to 2
  input wire logic [2:0] sec_out_i,
  input wire logic [2:0] sec_oe_n_i,
  output logic [2:0] sec_in_o,
  output logic sec_port_en_o,
  // Pace thresholds
  output logic [7:0] lead1_pace_threshold_o,
  output logic [7:0] lead2_pace_threshold_o,
  output logic [7:0] lead3_pace_threshold_o,
  // Neighbouring state
  input wire logic cal_mode_i,
  input wire logic gang_mode_i,
  input wire logic slave_mode_i,
  // Tone routing
  output logic [4:0] electrode_to_cm_o,
  output logic [4:0] electrode_to_tone_o,
  output logic ext_switch_open_o,
  output logic cal_pin_tone_o,
  output logic cal_dac_off_o,
  output logic tone_to_chain_o,
  output logic ac_leadoff_off_o,
  output logic tone_sine10_o,
  output logic tone_sine150_o,
  output logic tone_square1_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Mode field of pin n
  function automatic logic [1:0] mode_of(input logic [23:0] r, input int n);
    mode_of = r[gptc_pkg::PIN_STRIDE * n + gptc_pkg::MODE_OFS +: 2];
  endfunction

  // Places one readback bit per pin at its input position
  function automatic logic [23:0] spread_in(input logic [2:0] b);
    logic [23:0] w;
    w = gptc_pkg::RD_ZERO;
    for (int n = 0; n < gptc_pkg::NPIN; n++)
    begin
      w[gptc_pkg::PIN_STRIDE * n + gptc_pkg::IN_OFS] = b[n];
    end
    spread_in = w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [23:0] gpio_reg; // Pin modes, values, secondary enable
  logic [23:0] pace_reg; // Three lead thresholds
  logic [23:0] tone_reg; // Tone control
  logic [23:0] rdata_reg; // Read answer
  logic [2:0] pin_meta_reg; // First synchroniser stage
  logic [2:0] pin_sync_reg; // Second synchroniser stage

  //////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire sel_gpio = (addr_i == gptc_pkg::GPIO_IDX);
  wire sel_pace = (addr_i == gptc_pkg::PACE_IDX);
  wire sel_tone = (addr_i == gptc_pkg::TONE_IDX);
  wire wr_gpio = wr_i & sel_gpio;
  wire wr_pace = wr_i & sel_pace;
  wire wr_tone = wr_i & sel_tone;

  // Masked next values; read-only and reserved bits stay zero
  wire [23:0] gpio_next = wdata_i & gptc_pkg::GPIO_WMASK;
  wire [23:0] pace_next = wdata_i & gptc_pkg::PACE_WMASK;
  wire [23:0] tone_next = wdata_i & gptc_pkg::TONE_WMASK;

  //////////////////////////////////////////////////////////////////////////////
  // Register writes

  // GPIO control
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      gpio_reg <= gptc_pkg::GPIO_RST;
    else if (wr_gpio)
      gpio_reg <= gpio_next;
  end

  // Pace thresholds
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      pace_reg <= gptc_pkg::PACE_RST;
    else if (wr_pace)
      pace_reg <= pace_next;
  end

  // Test tone
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      tone_reg <= gptc_pkg::TONE_RST;
    else if (wr_tone)
      tone_reg <= tone_next;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin input sampling

  // Two-stage synchroniser for the pad levels
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end
    else
    begin
      pin_meta_reg <= pin_in_i;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Secondary port gets the synchronised levels
  assign sec_in_o = pin_sync_reg;
  wire sec_en = gpio_reg[gptc_pkg::SEC_EN_BIT];
  assign sec_port_en_o = sec_en;

  //////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  wire [2:0] in_bits; // Per-pin readback

  genvar g;
  generate
    for (g = 0; g < gptc_pkg::NPIN; g++)
    begin : pin_gen
      gptc_pin_if pin_bus ();
      // Fields of this pin
      assign pin_bus.mode = mode_of(gpio_reg, g);
      assign pin_bus.out_value = gpio_reg[gptc_pkg::PIN_STRIDE * g + gptc_pkg::VAL_OFS];
      assign pin_bus.sec_en = sec_en;
      assign pin_bus.sec_out = sec_out_i[g];
      assign pin_bus.sec_oe_n = sec_oe_n_i[g];
      // Readback only in input mode and while the pins are ours
      assign in_bits[g] = pin_sync_reg[g] & ~sec_en &
                          (mode_of(gpio_reg, g) == gptc_pkg::PM_IN);
      assign pin_out_o[g] = pin_bus.pin_out;
      assign pin_oe_n_o[g] = pin_bus.pin_oe_n;
      gptc_pin_ctrl u_pin (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .pin(pin_bus.pin)
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Pace threshold outputs

  assign lead1_pace_threshold_o = pace_reg[gptc_pkg::LEAD1_LSB +: gptc_pkg::PACE_W];
  assign lead2_pace_threshold_o = pace_reg[gptc_pkg::LEAD2_LSB +: gptc_pkg::PACE_W];
  assign lead3_pace_threshold_o = pace_reg[gptc_pkg::LEAD3_LSB +: gptc_pkg::PACE_W];

  //////////////////////////////////////////////////////////////////////////////
  // Tone routing

  wire [2:0] wave_sel;

  gptc_tone_route u_tone (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .tone_sel_i(tone_reg[gptc_pkg::SEL_LSB +: gptc_pkg::NELEC]),
    .tone_waveform_i(tone_reg[gptc_pkg::WAVE_LSB +: 2]),
    .tone_internal_route_i(tone_reg[gptc_pkg::INT_BIT]),
    .tone_pin_out_i(tone_reg[gptc_pkg::PINOUT_BIT]),
    .tone_enable_i(tone_reg[gptc_pkg::EN_BIT]),
    .cal_mode_i(cal_mode_i),
    .gang_mode_i(gang_mode_i),
    .slave_mode_i(slave_mode_i),
    .electrode_to_cm_o(electrode_to_cm_o),
    .electrode_to_tone_o(electrode_to_tone_o),
    .ext_switch_open_o(ext_switch_open_o),
    .cal_pin_tone_o(cal_pin_tone_o),
    .cal_dac_off_o(cal_dac_off_o),
    .tone_to_chain_o(tone_to_chain_o),
    .ac_leadoff_off_o(ac_leadoff_off_o),
    .wave_sel_o(wave_sel)
  );

  assign tone_sine10_o = wave_sel[0];
  assign tone_sine150_o = wave_sel[1];
  assign tone_square1_o = wave_sel[2];

  //////////////////////////////////////////////////////////////////////////////
  // Read path

  // Selected word; unmapped addresses read zero
  wire [23:0] rd_mux = sel_gpio ? (gpio_reg | spread_in(in_bits)) :
                       sel_pace ? pace_reg :
                       sel_tone ? tone_reg : gptc_pkg::RD_ZERO;

  // Answer stands only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_reg <= gptc_pkg::RD_ZERO;
    else if (rd_i)
      rdata_reg <= rd_mux;
    else
      rdata_reg <= gptc_pkg::RD_ZERO;
  end

  assign rdata_o = rdata_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  // Sticky marks of a first write, for reset checks
  logic gpio_seen_reg;
  logic pace_seen_reg;
  logic tone_seen_reg;

  // First-write trackers
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      gpio_seen_reg <= 1'b0;
      pace_seen_reg <= 1'b0;
      tone_seen_reg <= 1'b0;
    end
    else
    begin
      gpio_seen_reg <= gpio_seen_reg | wr_gpio;
      pace_seen_reg <= pace_seen_reg | wr_pace;
      tone_seen_reg <= tone_seen_reg | wr_tone;
    end
  end

  chk_gpio_reset: assert property (!gpio_seen_reg |-> gpio_reg == 24'h000000 && pin_oe_n_o == 3'h7) else $error("GPIO not at reset value");
  chk_pace_reset: assert property (!pace_seen_reg |-> lead1_pace_threshold_o == 8'h24 && lead3_pace_threshold_o == 8'h24) else $error("pace threshold reset wrong");
  chk_tone_reset: assert property (!tone_seen_reg |-> tone_reg == 24'h000000) else $error("tone register reset wrong");
  chk_pace_write: assert property (wr_pace ##1 rd_i && sel_pace |=> rdata_o == $past(wdata_i, 2)) else $error("pace write not read back");
  chk_mode_field: assert property (wr_gpio |=> mode_of(gpio_reg, 2) == $past(wdata_i[11:10]) && mode_of(gpio_reg, 0) == $past(wdata_i[3:2])) else $error("mode field misplaced");
  chk_in_readback: assert property (rd_i && sel_gpio && !sec_en && mode_of(gpio_reg, 1) == gptc_pkg::PM_IN |=> rdata_o[4] == $past(pin_sync_reg[1])) else $error("input readback wrong");
  chk_in_masked: assert property (rd_i && sel_gpio && mode_of(gpio_reg, 0) != gptc_pkg::PM_IN |=> !rdata_o[0]) else $error("input bit outside input mode");
  chk_tone_reserved: assert property (wr_tone |=> tone_reg[18:5] == 14'h0000) else $error("reserved tone bits stored");
  chk_pin_drive: assert property (wr_gpio && wdata_i[3:2] == 2'h2 && !wdata_i[16] |=> ##1 !pin_oe_n_o[0] && pin_out_o[0] == $past(wdata_i[1], 2)) else $error("pin 0 not driven");
  chk_idle_read: assert property (!rd_i |=> rdata_o == 24'h000000) else $error("read data outside answer cycle");
endmodule

//--- tb/gptc_pin_model.sv
// Behavioural model of the outside circuits on the three general-purpose pins
`timescale 1ns/1ns
module gptc_pin_model (
  input wire logic [2:0] pin_out_i,
  input wire logic [2:0] pin_oe_n_i,
  input wire logic [2:0] ext_en_i,
  input wire logic [2:0] ext_lvl_i,
  output logic [2:0] pad_o
);
  //////////////////////////////////////////////////////////////////////////////
  // Pad resolution: a pull-up holds a released pin high, clashing drivers give unknown
  always_comb
  begin
    for (int n = 0; n < 3; n++)
    begin
      if (!pin_oe_n_i[n] && ext_en_i[n])
        pad_o[n] = (pin_out_i[n] == ext_lvl_i[n]) ? pin_out_i[n] : 1'bx; // Contention
      else if (!pin_oe_n_i[n])
        pad_o[n] = pin_out_i[n]; // Device drives
      else if (ext_en_i[n])
        pad_o[n] = ext_lvl_i[n]; // Outside circuit drives
      else
        pad_o[n] = 1'b1; // Pull-up
    end
  end
endmodule

//--- tb/gpio_pace_tone_config_regs_bench.sv
// Self-checking bench of the GPIO, pace threshold and test tone register slice
`timescale 1ns/1ns
module gpio_pace_tone_config_regs_bench;
  logic clk_i, arst_n_i, wr_i, rd_i, sec_port_en_o;
  logic [7:0] addr_i, lead1_o, lead2_o, lead3_o;
  logic [23:0] wdata_i, rdata_o, d;
  logic [2:0] pad, pin_out_o, pin_oe_n_o, sec_out_i, sec_oe_n_i, sec_in_o, ext_en, ext_lvl;
  logic cal_mode_i, gang_mode_i, slave_mode_i;
  logic [4:0] to_cm, to_tone;
  logic sw_open, cal_pin, dac_off, to_chain, lo_off, sq1, s150, s10;
  int n_mismatch = 0;
  int tests_run = 0;

  //////////////////////////////////////////////////////////////////////////////
  // Design, and the outside circuits on its pins
  gptc_regs gptc_regs_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_in_i(pad),
    .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o), .sec_out_i(sec_out_i),
    .sec_oe_n_i(sec_oe_n_i), .sec_in_o(sec_in_o), .sec_port_en_o(sec_port_en_o),
    .lead1_pace_threshold_o(lead1_o), .lead2_pace_threshold_o(lead2_o),
    .lead3_pace_threshold_o(lead3_o), .cal_mode_i(cal_mode_i), .gang_mode_i(gang_mode_i),
    .slave_mode_i(slave_mode_i), .electrode_to_cm_o(to_cm), .electrode_to_tone_o(to_tone),
    .ext_switch_open_o(sw_open), .cal_pin_tone_o(cal_pin), .cal_dac_off_o(dac_off),
    .tone_to_chain_o(to_chain), .ac_leadoff_off_o(lo_off), .tone_sine10_o(s10),
    .tone_sine150_o(s150), .tone_square1_o(sq1));
  gptc_pin_model gptc_pin_model_i (.pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o),
    .ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .pad_o(pad));

  //////////////////////////////////////////////////////////////////////////////
  // Expected tone outputs, packed as the bench compares them
  function automatic logic [23:0] tone_exp(input logic [23:0] t, input logic c, g, s);
    tone_exp = {6'h0, ~t[23:19], t[23:19] & {5{t[2]}}, t[2],
      t[0] & !c & (!t[2] | t[1] | g), g & s & t[2] & t[0], t[0] & !c, t[0],
      t[4], t[4:3] == 2'h1, t[4:3] == 2'h0};
  endfunction
  // Expected pad enables and masked pad levels
  function automatic logic [5:0] pin_exp(input logic [23:0] w, input logic [2:0] so, soe);
    logic [1:0] m;
    logic v;
    pin_exp = 6'h38;
    for (int n = 0; n < 3; n++)
    begin
      m = w[4*n+3 -: 2];
      v = w[4*n+1];
      pin_exp[n+3] = w[16] ? soe[n] : !(m == 2'h2 || (m == 2'h3 && !v));
      pin_exp[n] = (w[16] ? so[n] : (m == 2'h2 && v)) & !pin_exp[n+3];
    end
  endfunction
  // Expected GPIO readback with the input bits
  function automatic logic [23:0] gpio_rd(input logic [23:0] w, input logic [2:0] xe, xl);
    gpio_rd = w & 24'h010eee;
    for (int n = 0; n < 3; n++)
      if (w[4*n+3 -: 2] == 2'h1 && !w[16])
        gpio_rd[4*n] = xe[n] ? xl[n] : 1'b1;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Comparison, bus cycles and verdict
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] w);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= w;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [23:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    close_out();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {arst_n_i, wr_i, rd_i, addr_i, wdata_i, sec_out_i, ext_en, ext_lvl} = '0;
    {cal_mode_i, gang_mode_i, slave_mode_i} = 3'h0;
    sec_oe_n_i = 3'h7;
    void'($urandom(32'h0cfd));
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    // Reset state
    rd(8'h06, 24'h000000);
    rd(8'h07, 24'h242424);
    rd(8'h08, 24'h000000);
    chk({18'h0, pin_oe_n_o, pin_out_o}, 24'h000038);
    chk({to_cm, to_tone, sw_open, cal_pin, dac_off, to_chain, lo_off, sq1, s150, s10},
      tone_exp(24'h0, 1'b0, 1'b0, 1'b0));
    // Unmapped places
    wr(8'h09, $urandom);
    rd(8'h09, 24'h000000);
    rd(8'h05, 24'h000000);
    // Pace thresholds
    for (int i = 0; i < 8; i++)
    begin
      d = (i == 0) ? 24'hff00ff : $urandom;
      wr(8'h07, d);
      rd(8'h07, d);
      chk({lead3_o, lead2_o, lead1_o}, d);
    end
    // Write then read with no gap between the strobes
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= 8'h07;
    wdata_i <= 24'h5a3c81;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, 24'h5a3c81);
    // Test tone: every control combination, calibration and gang inputs mixed in
    for (int i = 0; i < 64; i++)
    begin
      d = $urandom & 24'hf8001f;
      d[4:0] = i[4:0];
      @(posedge clk_i);
      cal_mode_i <= i[5];
      gang_mode_i <= $urandom;
      slave_mode_i <= $urandom;
      wr(8'h08, d);
      repeat (2) @(posedge clk_i);
      #1 chk({to_cm, to_tone, sw_open, cal_pin, dac_off, to_chain, lo_off, sq1, s150, s10},
        tone_exp(d, cal_mode_i, gang_mode_i, slave_mode_i));
      rd(8'h08, d);
    end
    // GPIO: all modes on all pins first, then random words with the secondary port
    for (int i = 0; i < 40; i++)
    begin
      d = $urandom & 24'hfef333;
      d = (i < 8) ? d | {12'h0, {3{i[1:0], 2'h0}}} : $urandom;
      @(posedge clk_i);
      ext_en <= $urandom;
      ext_lvl <= $urandom;
      sec_out_i <= $urandom;
      sec_oe_n_i <= $urandom;
      wr(8'h06, d);
      repeat (4) @(posedge clk_i);
      #1 chk({18'h0, pin_oe_n_o, pin_out_o & ~pin_oe_n_o},
        {18'h0, pin_exp(d, sec_out_i, sec_oe_n_i)});
      chk({21'h0, sec_in_o}, {21'h0, pad});
      chk({23'h0, sec_port_en_o}, {23'h0, d[16]});
      rd(8'h06, gpio_rd(d, ext_en, ext_lvl));
    end
    // Reset again in mid-run
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(8'h07, 24'h242424);
    rd(8'h06, 24'h000000);
    close_out();
  end
endmodule
